//--- pkg/pfls_pkg.sv
// Purpose: shared constants and types of the fault latch sequencer
// Assumes: mclk at 20 MHz
// Notes: derived cycle counts round least times up to whole cycles
package pfls_pkg;
	// ****************************************
	// clock and timing
	// ****************************************
	localparam int CLK_MHZ = 20;
	localparam int BLANK_NS = 1000; // blanking after turn-off
	localparam int MINW_NS = 600; // least valid comparator high time
	localparam int BLANK_CYC_I = (BLANK_NS * CLK_MHZ + 999) / 1000;
	localparam int MINW_CYC_I = (MINW_NS * CLK_MHZ + 999) / 1000;
	localparam logic [4:0] BLANK_CYC = 5'(BLANK_CYC_I);
	localparam logic [3:0] MINW_CYC = 4'(MINW_CYC_I);
	localparam int FAULT_MS = 200; // overload timer duration
	localparam int FAULT_CYC_I = FAULT_MS * CLK_MHZ * 1000;
	localparam int SS_CYC_I = 4000; // soft-start length, plain default
	// ****************************************
	// event counting and reset values
	// ****************************************
	localparam logic [2:0] EVT_LATCH = 3'h4; // successive events to latch
	localparam logic [22:0] TMR_RST = 23'h0;
	localparam logic [2:0] EVT_RST = 3'h0;
	// ****************************************
	// supply sequence states
	// ****************************************
	typedef enum logic [2:0] {
		ST_BOOT, ST_RUN, ST_DROP1, ST_IGNORE, ST_DROP2, ST_CHARGE
	} pfls_state_t;
endpackage

//--- rtl/pfls_sequencer.sv
// Purpose: light-load modes, overload hiccup and protection-pin latch
// Assumes: comparator inputs are asynchronous; pwm_on_req is on mclk
// Notes: arst_n stands for supply cycling; only it clears the latch
// How it works
// - overload flag starts the fault timer
// - timer expiry with flag held stops drive
// - first restart after fault is skipped
// - each restart begins with soft-start active
// - frequency foldback below the foldback threshold
// - peak setpoint frozen when feedback reaches 1 V
// - lower power enters skip, setpoint stays frozen
// - compensation ramp connected only during on-time
// - latched part clamps supply until power cycle
// - latch comparator compares protection pin to 3 V
// - comparator checked only after 1 us blanking
// - highs shorter than 600 ns are ignored
// - four successive events set the latch
// - latch stops drive pulses at once
`timescale 1ns/100ps
module pfls_sequencer #(
	parameter int FAULT_CYC = pfls_pkg::FAULT_CYC_I,
	parameter int SS_CYC = pfls_pkg::SS_CYC_I
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic pwm_on_req,
	input wire logic overload_flag,
	input wire logic fb_below_fold,
	input wire logic fb_below_freeze,
	input wire logic skip_cmp,
	input wire logic vcc_above_on,
	input wire logic vcc_below_min,
	input wire logic overvoltage_cmp,
	output logic gate_drive_q,
	output logic ramp_connect_q,
	output logic foldback_q,
	output logic setpoint_freeze_q,
	output logic skip_cycle_q,
	output logic soft_start_q,
	output logic fault_stop_q,
	output logic latched_q,
	output logic vcc_clamp_q
);
	import pfls_pkg::*;

	// ****************************************
	// input synchronisers
	// ****************************************
	logic [6:0] sync1_q;
	logic [6:0] sync2_q;
	wire logic [6:0] async_in = {overload_flag, fb_below_fold,
		fb_below_freeze, skip_cmp, vcc_above_on, vcc_below_min,
		overvoltage_cmp};
	// first stage feeds only the second stage
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q <= 7'h00;
			sync2_q <= 7'h00;
		end else begin
			sync1_q <= async_in;
			sync2_q <= sync1_q;
		end
	end
	wire logic ovl_s = sync2_q[6];
	wire logic fold_s = sync2_q[5];
	wire logic freeze_s = sync2_q[4];
	wire logic skip_s = sync2_q[3];
	wire logic von_s = sync2_q[2];
	wire logic vmin_s = sync2_q[1];
	wire logic ovp_s = sync2_q[0]; // 3 V comparator, off chip

	// ****************************************
	// overload timer and hiccup sequence
	// ****************************************
	pfls_state_t st_q, st_d;
	logic [22:0] tmr_q;
	logic [12:0] ss_cnt_q;
	wire logic tmr_hit = ovl_s && (tmr_q == 23'(FAULT_CYC - 1));
	// timer restarts from zero whenever the flag drops
	wire logic [22:0] tmr_d = (ovl_s && st_q == ST_RUN) ?
		tmr_q + 23'h1 : TMR_RST;
	wire logic restart = (st_q == ST_BOOT || st_q == ST_CHARGE) && von_s;

	// supply cycling states; the first recharge pass ignores the on threshold
	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_BOOT: if (von_s) st_d = ST_RUN;
			ST_RUN: begin
				if (tmr_hit) st_d = ST_DROP1;
				else if (vmin_s) st_d = ST_BOOT;
			end
			ST_DROP1: if (vmin_s) st_d = ST_IGNORE;
			ST_IGNORE: if (von_s) st_d = ST_DROP2;
			ST_DROP2: if (vmin_s) st_d = ST_CHARGE;
			ST_CHARGE: if (von_s) st_d = ST_RUN;
			default: st_d = ST_BOOT;
		endcase
	end
	// soft-start reloads on every entry to run
	wire logic [12:0] ss_cnt_d = restart ? 13'(SS_CYC) :
		(ss_cnt_q != 13'h0) ? ss_cnt_q - 13'h1 : 13'h0;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= ST_BOOT;
			tmr_q <= TMR_RST;
			ss_cnt_q <= 13'h0;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			ss_cnt_q <= ss_cnt_d;
		end
	end

	// ****************************************
	// protection pin qualification
	// ****************************************
	logic [4:0] blank_cnt_q;
	logic [3:0] hw_cnt_q;
	logic [2:0] evt_cnt_q;
	logic evt_seen_q;
	logic gate_prev_q;
	wire logic blank_done = !gate_drive_q && blank_cnt_q == BLANK_CYC;
	wire logic gate_rise = gate_drive_q && !gate_prev_q;
	// blanking restarts at every turn-off and saturates
	wire logic [4:0] blank_cnt_d = gate_drive_q ? 5'h0 :
		blank_done ? blank_cnt_q : blank_cnt_q + 5'h1;
	// width counter runs only inside the checked window
	wire logic [3:0] hw_cnt_d = (blank_done && ovp_s && !evt_seen_q) ?
		hw_cnt_q + 4'h1 : 4'h0;
	wire logic validate = hw_cnt_d == MINW_CYC;
	// a short high never reaches the width and is dropped
	wire logic clean_end = gate_rise && blank_cnt_q == BLANK_CYC &&
		!evt_seen_q;
	wire logic [2:0] evt_cnt_d = validate ? evt_cnt_q + 3'h1 :
		clean_end ? EVT_RST : evt_cnt_q;
	wire logic latch_d = latched_q || evt_cnt_d == EVT_LATCH;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			blank_cnt_q <= 5'h0;
			hw_cnt_q <= 4'h0;
			evt_cnt_q <= EVT_RST;
			evt_seen_q <= 1'b0;
			gate_prev_q <= 1'b0;
		end else begin
			blank_cnt_q <= blank_cnt_d;
			hw_cnt_q <= hw_cnt_d;
			evt_cnt_q <= evt_cnt_d;
			evt_seen_q <= gate_drive_q ? 1'b0 : (evt_seen_q || validate);
			gate_prev_q <= gate_drive_q;
		end
	end

	// ****************************************
	// output stage
	// ****************************************
	// skip only under freeze, so the setpoint stays frozen in skip
	wire logic skip_d = freeze_s && skip_s;
	wire logic run_d = st_d == ST_RUN;
	wire logic gate_d = pwm_on_req && run_d && !skip_d && !latch_d;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			gate_drive_q <= 1'b0;
			ramp_connect_q <= 1'b0;
			foldback_q <= 1'b0;
			setpoint_freeze_q <= 1'b0;
			skip_cycle_q <= 1'b0;
			soft_start_q <= 1'b0;
			fault_stop_q <= 1'b0;
			latched_q <= 1'b0;
			vcc_clamp_q <= 1'b0;
		end else begin
			gate_drive_q <= gate_d;
			ramp_connect_q <= gate_d;
			foldback_q <= fold_s;
			setpoint_freeze_q <= freeze_s;
			skip_cycle_q <= skip_d;
			soft_start_q <= ss_cnt_d != 13'h0;
			fault_stop_q <= !run_d && st_d != ST_BOOT;
			latched_q <= latch_d;
			vcc_clamp_q <= latch_d;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	property p_timer_start;
		$rose(ovl_s) && st_q == ST_RUN |=> tmr_q == 23'h1;
	endproperty
	a_timer_start: assert property (p_timer_start)
		else $error("fault timer did not start");
	property p_fault_stop;
		st_q == ST_RUN && tmr_hit |=> st_q == ST_DROP1 && !gate_drive_q
			&& fault_stop_q;
	endproperty
	a_fault_stop: assert property (p_fault_stop)
		else $error("timer expiry did not stop drive");
	property p_hiccup;
		st_q == ST_IGNORE && von_s |=> st_q == ST_DROP2 ##1 !gate_drive_q;
	endproperty
	a_hiccup: assert property (p_hiccup)
		else $error("first restart was not skipped");
	property p_soft_start;
		st_q == ST_CHARGE && von_s |=> st_q == ST_RUN && soft_start_q;
	endproperty
	a_soft_start: assert property (p_soft_start)
		else $error("restart without soft-start");
	property p_fold;
		fold_s |=> foldback_q;
	endproperty
	a_fold: assert property (p_fold)
		else $error("foldback not signalled");
	property p_skip_frozen;
		skip_cycle_q |-> setpoint_freeze_q && !gate_drive_q;
	endproperty
	a_skip_frozen: assert property (p_skip_frozen)
		else $error("skip without frozen setpoint");
	property p_ramp;
		ramp_connect_q == gate_drive_q;
	endproperty
	a_ramp: assert property (p_ramp)
		else $error("ramp connected during off-time");
	property p_latch_hold;
		latched_q |-> vcc_clamp_q && !gate_drive_q ##1 latched_q;
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("latch released or drive active");
	property p_blank;
		hw_cnt_q != 4'h0 |-> $past(blank_cnt_q) == BLANK_CYC;
	endproperty
	a_blank: assert property (p_blank)
		else $error("comparator sampled inside blanking");
	property p_width;
		evt_cnt_q == $past(evt_cnt_q) + 3'h1 |->
			$past(hw_cnt_q) == MINW_CYC - 4'h1 && $past(ovp_s);
	endproperty
	a_width: assert property (p_width)
		else $error("event counted below least width");
	property p_four;
		$rose(latched_q) |-> $past(evt_cnt_q) == EVT_LATCH - 3'h1;
	endproperty
	a_four: assert property (p_four)
		else $error("latch without four events");
	property p_clear;
		clean_end && !validate |=> evt_cnt_q == EVT_RST;
	endproperty
	a_clear: assert property (p_clear)
		else $error("event count not cleared");
	c_latch: cover property ($rose(latched_q));
	c_hiccup: cover property (st_q == ST_CHARGE && von_s);
	c_skip: cover property ($rose(skip_cycle_q));
	c_event: cover property (validate);
endmodule // pfls_sequencer

//--- tb/pfls_far_model.sv
// Purpose: supply rail and protection-pin model facing the sequencer
// Assumes: gate_drive_q and fault_stop_q come from the sequencer
// Notes: rail sits at the turn-on level while the part switches
`timescale 1ns/100ps
module pfls_far_model (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic gate_drive_q,
	input wire logic fault_stop_q,
	input wire logic [7:0] ov_start,
	input wire logic [7:0] ov_len,
	output logic vcc_above_on,
	output logic vcc_below_min,
	output logic overvoltage_cmp
);
	logic [3:0] lvl_q;
	logic down_q;
	logic [7:0] off_q;
	// no aux pulses in a fault stop: rail droops, then recharges
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lvl_q <= 4'h8;
			down_q <= 1'b1;
		end else if (!fault_stop_q) begin
			lvl_q <= 4'h8;
			down_q <= 1'b1;
		end else if (down_q) begin
			lvl_q <= lvl_q - 4'h1;
			down_q <= lvl_q != 4'h1;
		end else begin
			lvl_q <= lvl_q + 4'h1;
			down_q <= lvl_q == 4'h7;
		end
	end
	// off-time age, saturating so a long stop never wraps
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			off_q <= 8'h0;
		else if (gate_drive_q)
			off_q <= 8'h0;
		else if (off_q != 8'hff)
			off_q <= off_q + 8'h1;
	end
	// comparator levels seen by the sequencer
	assign vcc_above_on = lvl_q == 4'h8;
	assign vcc_below_min = lvl_q == 4'h0;
	assign overvoltage_cmp = !gate_drive_q && off_q >= ov_start
		&& off_q < ov_start + ov_len;
endmodule // pfls_far_model

//--- tb/tb_top.sv
// Purpose: self-checking bench of the fault latch sequencer
// Assumes: short fault timer (50) and soft-start (10) parameters
// Notes: mode outputs lag their pins by three edges
`timescale 1ns/100ps
module tb_top;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic pwm_on_req = 1'b0;
	logic overload_flag = 1'b0;
	logic fb_below_fold = 1'b0;
	logic fb_below_freeze = 1'b0;
	logic skip_cmp = 1'b0;
	logic [7:0] ov_start = 8'h0;
	logic [7:0] ov_len = 8'h0;
	logic vcc_above_on, vcc_below_min, overvoltage_cmp;
	logic gate_drive_q, ramp_connect_q, foldback_q, setpoint_freeze_q;
	logic skip_cycle_q, soft_start_q, fault_stop_q, latched_q, vcc_clamp_q;
	int miscompares = 0;
	int n_compared = 0;
	always #25 mclk = ~mclk;
	pfls_sequencer #(.FAULT_CYC(50), .SS_CYC(10)) dut_u (.mclk(mclk),
		.arst_n(arst_n), .pwm_on_req(pwm_on_req),
		.overload_flag(overload_flag), .fb_below_fold(fb_below_fold),
		.fb_below_freeze(fb_below_freeze), .skip_cmp(skip_cmp),
		.vcc_above_on(vcc_above_on), .vcc_below_min(vcc_below_min),
		.overvoltage_cmp(overvoltage_cmp), .gate_drive_q(gate_drive_q),
		.ramp_connect_q(ramp_connect_q), .foldback_q(foldback_q),
		.setpoint_freeze_q(setpoint_freeze_q), .skip_cycle_q(skip_cycle_q),
		.soft_start_q(soft_start_q), .fault_stop_q(fault_stop_q),
		.latched_q(latched_q), .vcc_clamp_q(vcc_clamp_q));
	pfls_far_model far_u (.mclk(mclk), .arst_n(arst_n),
		.gate_drive_q(gate_drive_q), .fault_stop_q(fault_stop_q),
		.ov_start(ov_start), .ov_len(ov_len), .vcc_above_on(vcc_above_on),
		.vcc_below_min(vcc_below_min), .overvoltage_cmp(overvoltage_cmp));
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// inputs always move 1 ns after the rising edge
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wrap_up();
		$display("compared=%0d miscompares=%0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic do_reset();
		arst_n = 1'b0;
		step(3);
		chk({gate_drive_q, fault_stop_q, latched_q, vcc_clamp_q}, 9'h0);
		arst_n = 1'b1;
		step(4);
	endtask
	// one switching cycle, protection pin high in a chosen off-time slot
	task automatic off_cyc(input logic [7:0] st, input logic [7:0] ln);
		ov_start = st;
		ov_len = ln;
		pwm_on_req = 1'b1;
		step(4);
		pwm_on_req = 1'b0;
		step(60);
	endtask
	task automatic test_run();
		pwm_on_req = 1'b1;
		step(1);
		chk({gate_drive_q, ramp_connect_q}, 9'h3);
		pwm_on_req = 1'b0;
		step(1);
		chk({gate_drive_q, ramp_connect_q}, 9'h0);
		$display("test run done");
	endtask
	task automatic test_modes();
		fb_below_fold = 1'b1;
		step(3);
		chk({foldback_q, setpoint_freeze_q}, 9'h2);
		fb_below_freeze = 1'b1;
		step(3);
		chk({setpoint_freeze_q, skip_cycle_q}, 9'h2);
		skip_cmp = 1'b1;
		pwm_on_req = 1'b1;
		step(3);
		chk({setpoint_freeze_q, skip_cycle_q, gate_drive_q}, 9'h6);
		fb_below_freeze = 1'b0;
		fb_below_fold = 1'b0;
		step(3);
		chk({foldback_q, skip_cycle_q, gate_drive_q}, 9'h1);
		skip_cmp = 1'b0;
		pwm_on_req = 1'b0;
		$display("test modes done");
	endtask
	task automatic test_latch();
		// runs of three events, broken by a high inside blanking only
		// and then by a high too short to count
		repeat (3) off_cyc(8'h16, 8'h10);
		off_cyc(8'h01, 8'h0e);
		repeat (3) off_cyc(8'h16, 8'h10);
		off_cyc(8'h16, 8'h06);
		repeat (3) off_cyc(8'h16, 8'h10);
		chk(latched_q, 9'h0);
		off_cyc(8'h16, 8'h10);
		pwm_on_req = 1'b1;
		step(3);
		chk({latched_q, vcc_clamp_q, gate_drive_q}, 9'h6);
		chk(gate_drive_q, 9'h0);
		do_reset();
		chk({latched_q, vcc_clamp_q, gate_drive_q}, 9'h1);
		$display("test latch done");
	endtask
	task automatic test_hiccup();
		int n;
		int ons;
		logic prev;
		repeat (2) begin
			overload_flag = 1'b1;
			step(30);
			overload_flag = 1'b0;
			step(5);
		end
		chk({fault_stop_q, gate_drive_q}, 9'h1);
		overload_flag = 1'b1;
		n = 0;
		while (fault_stop_q !== 1'b1 && n < 100) begin
			step(1);
			n++;
		end
		chk(n >= 48 && n <= 56, 9'h1);
		chk(gate_drive_q, 9'h0);
		overload_flag = 1'b0;
		ons = 0;
		prev = vcc_above_on;
		while (fault_stop_q !== 1'b0 && n < 400) begin
			step(1);
			n++;
			if (vcc_above_on && !prev)
				ons++;
			prev = vcc_above_on;
		end
		// a loop that ran out leaves the stop standing
		chk(fault_stop_q, 9'h0);
		chk(9'(ons), 9'h2);
		chk(soft_start_q, 9'h1);
		step(15);
		chk({soft_start_q, gate_drive_q}, 9'h1);
		$display("test hiccup done");
	endtask
	// watchdog: the whole run needs well under 200 us
	initial begin
		#500000;
		miscompares++;
		wrap_up();
	end
	initial begin
		do_reset();
		test_run();
		test_modes();
		test_latch();
		test_hiccup();
		wrap_up();
	end
endmodule // tb_top
